// ---- ebslc_strobe_ctrl.sv ----
// Strobe, chip select, write strobe and parity pin control for DRAM and external memory.
//
// Behaviour
// - Row address strobe is low while the row address is on the address lines of a DRAM access.
// - An 8-bit DRAM access strobes only the lower column strobe; the upper stays high.
// - A 16-bit DRAM access including the upper byte drives the upper column strobe low.
// - A 16-bit DRAM access including the lower byte drives the lower column strobe low.
// - With DRAM parity selected, parity pins carry parity on active lanes of DRAM writes, else float.
// - With area 2 parity selected, parity pins carry parity on active lanes of area 2 writes.
// - An external memory access drives low only the chip select of the addressed area.
// - An 8-bit external memory access leaves the shared upper write/lower byte pin unused.
`timescale 1ns/10ps
`include "ebslc_params.svh"
module ebslc_strobe_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Access request from the bus controller
  input wire logic req,
  input wire logic req_dram,
  input wire logic [2:0] req_area,
  input wire logic req_bus16,
  input wire logic req_upper,
  input wire logic req_lower,
  input wire logic req_write,
  input wire logic req_byte_sel_mode,
  input wire logic [21:0] row_addr,
  input wire logic [21:0] col_addr,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] parity_check_select,
  output logic busy,
  // External bus pins, strobes active low
  output logic [21:0] addr_out,
  output logic row_strobe_n,
  output logic upper_column_strobe_n,
  output logic lower_column_strobe_n,
  output logic [7:0] area_chip_selects_n,
  output logic upper_write_strobe_n,
  output logic lower_write_strobe_n,
  output logic upper_byte_select_n,
  output logic upper_parity_line,
  output logic upper_parity_line_oe,
  output logic lower_parity_line,
  output logic lower_parity_line_oe
);
  // ----------------------------------------------------------------
  // Access state
  // ----------------------------------------------------------------
  ebslc_pkg::ebslc_state_e state_ff, nxt_state;
  logic dram_ff, nxt_dram;
  logic [2:0] area_ff, nxt_area;
  logic bus16_ff, nxt_bus16;
  logic up_ff, nxt_up;
  logic lo_ff, nxt_lo;
  logic wr_ff, nxt_wr;
  logic bsel_ff, nxt_bsel;
  logic [21:0] col_ff, nxt_col;
  logic [21:0] addr_ff, nxt_addr;
  logic [15:0] data_ff, nxt_data;
  logic [1:0] pchk_ff, nxt_pchk;

  always_comb begin
    nxt_state = state_ff;
    nxt_dram = dram_ff;
    nxt_area = area_ff;
    nxt_bus16 = bus16_ff;
    nxt_up = up_ff;
    nxt_lo = lo_ff;
    nxt_wr = wr_ff;
    nxt_bsel = bsel_ff;
    nxt_col = col_ff;
    nxt_addr = addr_ff;
    nxt_data = data_ff;
    nxt_pchk = pchk_ff;
    case (state_ff)
      ebslc_pkg::EBSLC_IDLE: begin
        if (req) begin
          nxt_dram = req_dram;
          nxt_area = req_area;
          nxt_bus16 = req_bus16;
          // An 8-bit space only has the lower lane.
          nxt_up = req_bus16 & req_upper;
          nxt_lo = req_bus16 ? req_lower : 1'b1;
          nxt_wr = req_write;
          nxt_bsel = req_byte_sel_mode;
          nxt_col = col_addr;
          nxt_addr = row_addr;
          nxt_data = wr_data;
          nxt_pchk = parity_check_select;
          nxt_state = req_dram ? ebslc_pkg::EBSLC_ROW : ebslc_pkg::EBSLC_MEM;
        end
      end
      ebslc_pkg::EBSLC_ROW: begin
        nxt_addr = col_ff;
        nxt_state = ebslc_pkg::EBSLC_COL;
      end
      ebslc_pkg::EBSLC_COL: nxt_state = ebslc_pkg::EBSLC_IDLE;
      ebslc_pkg::EBSLC_MEM: nxt_state = ebslc_pkg::EBSLC_IDLE;
      default: nxt_state = ebslc_pkg::EBSLC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ebslc_pkg::EBSLC_IDLE;
      dram_ff <= 1'b0;
      area_ff <= 3'h0;
      bus16_ff <= 1'b0;
      up_ff <= 1'b0;
      lo_ff <= 1'b0;
      wr_ff <= 1'b0;
      bsel_ff <= 1'b0;
      col_ff <= 22'h00_0000;
      addr_ff <= 22'h00_0000;
      data_ff <= 16'h0000;
      pchk_ff <= `EBSLC_PCHK_NONE;
    end else begin
      state_ff <= nxt_state;
      dram_ff <= nxt_dram;
      area_ff <= nxt_area;
      bus16_ff <= nxt_bus16;
      up_ff <= nxt_up;
      lo_ff <= nxt_lo;
      wr_ff <= nxt_wr;
      bsel_ff <= nxt_bsel;
      col_ff <= nxt_col;
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
      pchk_ff <= nxt_pchk;
    end
  end

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  logic in_row, in_col, in_mem, in_dram, par_on;
  assign in_row = (state_ff == ebslc_pkg::EBSLC_ROW);
  assign in_col = (state_ff == ebslc_pkg::EBSLC_COL);
  assign in_mem = (state_ff == ebslc_pkg::EBSLC_MEM);
  assign in_dram = in_row | in_col;
  assign busy = (state_ff != ebslc_pkg::EBSLC_IDLE);
  assign addr_out = addr_ff;

  // Row strobe stays low through the column phase, as DRAM requires.
  assign row_strobe_n = ~in_dram;
  // For 8-bit accesses up_ff is forced clear, so only the lower strobe moves.
  assign upper_column_strobe_n = ~(in_col & up_ff);
  assign lower_column_strobe_n = ~(in_col & lo_ff);

  logic [7:0] cs_sel;
  always_comb begin
    cs_sel = `EBSLC_CS_IDLE;
    if (in_mem) begin
      cs_sel[area_ff] = 1'b0;
    end else if (in_dram & ~bus16_ff) begin
      // The area 1 select doubles as the upper column strobe in 16-bit DRAM, so 8-bit only.
      cs_sel[`EBSLC_DRAM_AREA] = 1'b0;
    end
  end
  assign area_chip_selects_n = cs_sel;

  logic wr_phase;
  assign wr_phase = wr_ff & (in_mem | in_col);
  always_comb begin
    upper_write_strobe_n = 1'b1;
    lower_write_strobe_n = 1'b1;
    upper_byte_select_n = 1'b1;
    if (in_mem & ~bus16_ff) begin
      lower_write_strobe_n = ~wr_ff;
    end else if (in_mem & bsel_ff) begin
      // Single write strobe with byte selects; the shared pin carries the lower select.
      lower_write_strobe_n = ~wr_ff;
      upper_write_strobe_n = ~lo_ff;
      upper_byte_select_n = ~up_ff;
    end else if (wr_phase) begin
      upper_write_strobe_n = ~up_ff;
      lower_write_strobe_n = ~lo_ff;
    end
  end

  // ----------------------------------------------------------------
  // Parity lanes
  // ----------------------------------------------------------------
  assign par_on = (in_dram & (pchk_ff == `EBSLC_PCHK_DRAM))
    | (in_mem & (pchk_ff == `EBSLC_PCHK_AREA2) & (area_ff == `EBSLC_PARITY_AREA));

  ebslc_lane_parity u_upper_par (
    .lane_data(data_ff[15:8]),
    .lane_active(up_ff & wr_ff),
    .check_on(par_on),
    .par_out(upper_parity_line),
    .par_oe(upper_parity_line_oe)
  );
  ebslc_lane_parity u_lower_par (
    .lane_data(data_ff[7:0]),
    .lane_active(lo_ff & wr_ff),
    .check_on(par_on),
    .par_out(lower_parity_line),
    .par_oe(lower_parity_line_oe)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  row_then_col_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_row |=> !row_strobe_n && addr_out == $past(col_ff)) else $error("row phase wrong");
  narrow_upper_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_col && !bus16_ff |-> upper_column_strobe_n && !lower_column_strobe_n)
    else $error("8-bit column strobe wrong");
  upper_cas_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_col && bus16_ff |-> upper_column_strobe_n == !up_ff) else $error("upper strobe");
  lower_cas_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_col && bus16_ff |-> lower_column_strobe_n == !lo_ff) else $error("lower strobe");
  dram_par_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_dram && pchk_ff == `EBSLC_PCHK_DRAM && wr_ff |->
    lower_parity_line_oe == lo_ff && upper_parity_line_oe == up_ff)
    else $error("dram parity lanes");
  area2_par_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_mem && pchk_ff == `EBSLC_PCHK_AREA2 && area_ff != `EBSLC_PARITY_AREA |->
    !lower_parity_line_oe && !upper_parity_line_oe) else $error("area parity");
  one_select_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_mem |-> $countones(~area_chip_selects_n) == 1 && !area_chip_selects_n[area_ff])
    else $error("chip select");
  shared_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    in_mem && !bus16_ff |-> upper_write_strobe_n) else $error("shared pin used");
endmodule : ebslc_strobe_ctrl

// ---- ebslc_params.svh ----
// Timing counts, field encodings and reset values for the external bus strobe block.
`ifndef EBSLC_PARAMS_SVH
`define EBSLC_PARAMS_SVH
`define EBSLC_PCHK_NONE 2'h0
`define EBSLC_PCHK_DRAM 2'h1
`define EBSLC_PCHK_AREA2 2'h2
`define EBSLC_PARITY_AREA 3'h2
`define EBSLC_DRAM_AREA 3'h1
`define EBSLC_CS_IDLE 8'hff
`define EBSLC_ROW_CYC 2'h1
`define EBSLC_COL_CYC 2'h1
`endif

// ---- ebslc_pkg.sv ----
// Types shared by the external bus strobe block.
package ebslc_pkg;
  typedef enum logic [3:0] {
    EBSLC_IDLE = 4'b0001,
    EBSLC_ROW = 4'b0010,
    EBSLC_COL = 4'b0100,
    EBSLC_MEM = 4'b1000
  } ebslc_state_e;
endpackage : ebslc_pkg

// ---- ebslc_lane_parity.sv ----
// One byte lane of parity: even parity out, tri-state control by lane activity.
`timescale 1ns/10ps
module ebslc_lane_parity (
  // Lane data
  input wire logic [7:0] lane_data,
  input wire logic lane_active,
  input wire logic check_on,
  // Parity pin
  output logic par_out,
  output logic par_oe
);
  assign par_out = ^lane_data;
  assign par_oe = lane_active & check_on;
endmodule : ebslc_lane_parity

// ---- ebslc_dram_model.sv ----
// Behavioural external DRAM that latches row and column addresses off the strobes.
`timescale 1ns/10ps
module ebslc_dram_model (
  // Clock
  input wire logic clk,
  // Bus pins
  input wire logic [21:0] addr_out,
  input wire logic row_strobe_n,
  input wire logic upper_column_strobe_n,
  input wire logic lower_column_strobe_n,
  // Captured access
  output logic [21:0] seen_row_ff,
  output logic [21:0] seen_col_ff,
  output logic [1:0] seen_lanes_ff
);
  logic row_prev_ff;
  // A real part latches on the falling strobe, so only the first row strobe low cycle counts; the column is taken on every low cycle.
  always_ff @(posedge clk) begin
    row_prev_ff <= row_strobe_n;
    if (row_prev_ff && !row_strobe_n) seen_row_ff <= addr_out;
    if (!upper_column_strobe_n || !lower_column_strobe_n) begin
      seen_col_ff <= addr_out;
      seen_lanes_ff <= {!upper_column_strobe_n, !lower_column_strobe_n};
    end
  end
endmodule : ebslc_dram_model

// ---- ext_bus_strobe_lane_control_tb_top.sv ----
// Self-checking testbench for the external bus strobe block.
`timescale 1ns/10ps
`include "ebslc_params.svh"
module ext_bus_strobe_lane_control_tb_top;
  logic clk = 0, sys_rst = 1, req = 0, req_dram = 0, req_bus16 = 0, req_upper = 0;
  logic req_lower = 0, req_write = 0, req_byte_sel_mode = 0, busy;
  logic [2:0] req_area = 3'h0;
  logic [21:0] row_addr = 22'h00_0000, col_addr = 22'h00_0000, addr_out, seen_row, seen_col;
  logic [15:0] wr_data = 16'h0000;
  logic [1:0] parity_check_select = 2'h0, seen_lanes;
  logic [7:0] area_chip_selects_n;
  logic row_strobe_n, upper_column_strobe_n, lower_column_strobe_n, upper_write_strobe_n;
  logic lower_write_strobe_n, upper_byte_select_n, upper_parity_line, upper_parity_line_oe;
  logic lower_parity_line, lower_parity_line_oe;
  int mismatches = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  ebslc_strobe_ctrl dut_u (.clk, .sys_rst, .req, .req_dram, .req_area, .req_bus16, .req_upper,
    .req_lower, .req_write, .req_byte_sel_mode, .row_addr, .col_addr, .wr_data,
    .parity_check_select, .busy, .addr_out, .row_strobe_n, .upper_column_strobe_n,
    .lower_column_strobe_n, .area_chip_selects_n, .upper_write_strobe_n, .lower_write_strobe_n,
    .upper_byte_select_n, .upper_parity_line, .upper_parity_line_oe, .lower_parity_line,
    .lower_parity_line_oe);
  ebslc_dram_model mem_u (.clk, .addr_out, .row_strobe_n, .upper_column_strobe_n,
    .lower_column_strobe_n, .seen_row_ff(seen_row), .seen_col_ff(seen_col),
    .seen_lanes_ff(seen_lanes));
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Leaves the caller in the first cycle of the access, after the take edge has settled.
  task automatic start(input logic dram, input logic [2:0] area, input logic b16, input logic up,
    input logic lo, input logic [1:0] pc, input logic [15:0] d, input logic wr = 1'b1,
    input logic bs = 1'b0);
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      @(posedge clk);
      #2;
      n++;
      if (n > 20) begin
        mismatches++;
        report_and_stop();
      end
    end
    @(posedge clk);
    req <= 1;
    req_dram <= dram;
    req_area <= area;
    req_bus16 <= b16;
    req_upper <= up;
    req_lower <= lo;
    req_write <= wr;
    req_byte_sel_mode <= bs;
    parity_check_select <= pc;
    wr_data <= d;
    row_addr <= {6'h15, d};
    col_addr <= {6'h2a, ~d};
    @(posedge clk);
    req <= 0;
    #2;
  endtask : start
  task automatic dram8;
    start(1, 3'h1, 0, 1, 1, `EBSLC_PCHK_DRAM, 16'h00a7);
    check("busy", busy, 1);
    check("row strobe", row_strobe_n, 0);
    check("row address", addr_out, {6'h15, 16'h00a7});
    @(posedge clk);
    #2;
    check("column strobes", {upper_column_strobe_n, lower_column_strobe_n}, 2'b10);
    check("parity", {upper_parity_line_oe, lower_parity_line_oe, lower_parity_line},
      {2'b01, ^8'ha7});
    @(posedge clk);
    #2;
    check("row seen", seen_row, {6'h15, 16'h00a7});
    check("lanes seen", seen_lanes, 2'b01);
    check("column seen", seen_col, {6'h2a, 16'hff58});
  endtask : dram8
  task automatic dram16;
    for (int i = 1; i < 4; i++) begin
      start(1, 3'h1, 1, i[1], i[0], `EBSLC_PCHK_DRAM, 16'h5c3e);
      @(posedge clk);
      #2;
      check("upper column strobe", upper_column_strobe_n, !i[1]);
      check("lower column strobe", lower_column_strobe_n, !i[0]);
      check("parity enables", {upper_parity_line_oe, lower_parity_line_oe}, i[1:0]);
      if (i == 3) check("upper parity", upper_parity_line, ^8'h5c);
    end
  endtask : dram16
  task automatic mem_areas;
    for (int a = 0; a < 8; a++) begin
      start(0, a[2:0], 1, 1, 1, `EBSLC_PCHK_AREA2, 16'h9617);
      check("chip selects", area_chip_selects_n, 8'(~(8'h01 << a)));
      check("word write strobes", {upper_write_strobe_n, lower_write_strobe_n}, 2'b00);
      check("parity enables", {upper_parity_line_oe, lower_parity_line_oe},
        (a == 2) ? 2'b11 : 2'b00);
    end
  endtask : mem_areas
  // The upper lane request is set on purpose: an 8-bit space must ignore it.
  task automatic mem8;
    start(0, 3'h3, 0, 1, 1, `EBSLC_PCHK_NONE, 16'h0042);
    check("shared write pin", upper_write_strobe_n, 1);
    check("lower write strobe", lower_write_strobe_n, 0);
  endtask : mem8
  // Byte-select system reads in area 2: selects follow the lanes, parity stays off on reads.
  task automatic bsel_reads;
    for (int i = 1; i < 4; i++) begin
      start(0, 3'h2, 1, i[1], i[0], `EBSLC_PCHK_AREA2, 16'h3c81, 1'b0, 1'b1);
      check("byte selects", {upper_byte_select_n, upper_write_strobe_n},
        {!i[1], !i[0]});
      check("read strobe", lower_write_strobe_n, 1);
      check("read select", area_chip_selects_n, 8'hfb);
      check("read parity", {upper_parity_line_oe, lower_parity_line_oe}, 2'b00);
    end
  endtask : bsel_reads
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    dram8();
    dram16();
    mem_areas();
    mem8();
    bsel_reads();
    report_and_stop();
  end
endmodule : ext_bus_strobe_lane_control_tb_top
